/* File: hw/irrc_defines.svh */
`ifndef IRRC_DEFINES_SVH
`define IRRC_DEFINES_SVH

// Register indexes; the byte address on the bus is four times the index.
`define IRRC_IDX_SHARED   10'h090
`define IRRC_IDX_CTRL     10'h0B0
`define IRRC_IDX_STATUS   10'h0B1
`define IRRC_IDX_RXCNT    10'h0B2
`define IRRC_IDX_TXCNT    10'h0B3
`define IRRC_IDX_RXFIFO   10'h0B4
`define IRRC_IDX_TXFIFO   10'h0B5
`define IRRC_IDX_TXERR    10'h0B6

// Field positions.
`define IRRC_CTRL_START   0
`define IRRC_CTRL_FORMAT  1
`define IRRC_CTRL_RX_DONE_IRQ_ENABLE    2
`define IRRC_CTRL_TX_DONE_IRQ_ENABLE    3
`define IRRC_ST_RBFER     0
`define IRRC_ST_RDI       2
`define IRRC_ST_TDI       3
`define IRRC_SH_SUMMARY   4
`define IRRC_ERR_LEN      0

// Reset values and fixed data values.
`define IRRC_RST_BYTE     8'h00
`define IRRC_EMPTY_READ   8'hFF
`define IRRC_CNT_MAX      8'hFF

// Timing: unit times in ns, clock period in ns, durations in half units.
`define IRRC_CLK_NS       10
`define IRRC_FMT0_UNIT_NS 562500
`define IRRC_FMT1_UNIT_NS 425000
`define IRRC_F0_LMARK     6'd32
`define IRRC_F0_LSPACE    6'd16
`define IRRC_F1_LMARK     6'd16
`define IRRC_F1_LSPACE    6'd8
`define IRRC_BIT_MARK     6'd2
`define IRRC_ZERO_SPACE   6'd2
`define IRRC_ONE_SPACE    6'd6
`define IRRC_STOP_MARK    6'd2
`define IRRC_TRAIL_SPACE  6'd16
`define IRRC_RX_ONE_MIN   6'd4
`define IRRC_RX_LEAD_MIN  6'd12
`define IRRC_RX_END       6'd20
`define IRRC_LEN_MAX      6'd63

`endif

/* File: hw/irrc_pkg.sv */
package irrc_pkg;

   typedef enum logic [6:0] {
      T_IDLE   = 7'h01,
      T_LMARK  = 7'h02,
      T_LSPACE = 7'h04,
      T_BMARK  = 7'h08,
      T_BSPACE = 7'h10,
      T_STOP   = 7'h20,
      T_TRAIL  = 7'h40
   } tx_state_e;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        start;
      logic        fmt;
      logic        rx_done_irq_enable;
      logic        tx_done_irq_enable;
      logic        rx_frame_done_flag;
      logic        tdi;
      logic        rbfer;
      logic        lenerr;
      logic        sumf;
      logic        irq;
      logic [8:0]  tx_fill;
      logic [7:0]  tx_wp;
      logic [7:0]  tx_rp;
      logic [7:0]  tx_pend;
      logic [7:0]  wr_rem;
      tx_state_e   tst;
      logic [5:0]  tx_len;
      logic [7:0]  tx_left;
      logic [7:0]  tx_sh;
      logic [2:0]  tx_bit;
      logic        tx_out;
      logic [7:0]  rx_occ;
      logic [7:0]  rx_wp;
      logic [7:0]  rx_rp;
      logic [7:0]  rx_fb;
      logic        rx_prev;
      logic        rx_in_fr;
      logic        rx_skip;
      logic        rx_drop;
      logic [5:0]  rx_len;
      logic [7:0]  rx_sh;
      logic [2:0]  rx_bit;
   } state_s;

endpackage : irrc_pkg

/* File: hw/ir_half_unit_tick.sv */
`timescale 1ns/10ps
module ir_half_unit_tick #(
   parameter int HALF0 = 28125,
   parameter int HALF1 = 21250
) (
   input  wire logic CORE_CLK, // System clock.
   input  wire logic RESET_N,  // Synchronous reset, active low.
   input  wire logic clear,    // Restart the phase of the divider.
   input  wire logic fmt,      // Selects the unit time of the format.
   output logic      tick      // One-cycle pulse every half unit.
);
   if (HALF0 < 2 || HALF1 < 2 || HALF0 > 131071 || HALF1 > 131071) begin : g_bad
      $error("half unit counts out of range");
   end

   localparam logic [16:0] TOP0 = 17'(HALF0 - 1);
   localparam logic [16:0] TOP1 = 17'(HALF1 - 1);

   logic [16:0] cnt_r;
   logic [16:0] top;

   assign top  = fmt ? TOP1 : TOP0;
   assign tick = (cnt_r == top) && !clear;

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N || clear || cnt_r >= top) begin
         cnt_r <= 17'h00000;
      end else begin
         cnt_r <= cnt_r + 17'h00001;
      end
   end
endmodule : ir_half_unit_tick

/* File: hw/infrared_remote_transceiver.sv */
`timescale 1ns/10ps
`include "irrc_defines.svh"

module infrared_remote_transceiver #(
   parameter int FIFO_DEPTH = 256,
   parameter int HALF0_CYC  = `IRRC_FMT0_UNIT_NS / `IRRC_CLK_NS / 2,
   parameter int HALF1_CYC  = `IRRC_FMT1_UNIT_NS / `IRRC_CLK_NS / 2
) (
   input  wire logic        CORE_CLK,  // System clock, 100 MHz.
   input  wire logic        RESET_N,   // Synchronous reset, active low.
   input  wire logic        PSEL,      // APB select.
   input  wire logic        PENABLE,   // APB access phase.
   input  wire logic        PWRITE,    // APB write direction.
   input  wire logic [11:0] PADDR,     // APB byte address.
   input  wire logic [31:0] PWDATA,    // APB write data.
   output logic             PREADY,    // APB ready.
   output logic [31:0]      PRDATA,    // APB read data.
   output logic             PSLVERR,   // APB error for unmapped address.
   output logic             IR_TX_OUT, // Emitter drive, high during mark.
   input  wire logic        IR_RX_IN,  // Demodulated receiver, high during mark.
   output logic             IR_IRQ     // Frame done interrupt, active high.
);
   if (FIFO_DEPTH != 256) begin : g_bad_depth
      $error("FIFO_DEPTH must be 256 for the 8-bit pointers");
   end

   irrc_pkg::state_s s, n;
   logic [7:0] rx_mem [FIFO_DEPTH];
   logic [7:0] tx_mem [FIFO_DEPTH];
   logic       rx_we;
   logic [7:0] rx_waddr;
   logic [7:0] rx_wdata;
   logic       tx_we;
   logic       tx_tick;
   logic       rx_tick;
   logic       acc_first;
   logic       acc_done;
   logic       rx_edge;

   function automatic logic addr_is(input logic [11:0] a, input logic [9:0] idx);
      return a == {idx, 2'b00};
   endfunction : addr_is

   function automatic logic [5:0] lead_mark(input logic f);
      return f ? `IRRC_F1_LMARK : `IRRC_F0_LMARK;
   endfunction : lead_mark

   function automatic logic [5:0] lead_space(input logic f);
      return f ? `IRRC_F1_LSPACE : `IRRC_F0_LSPACE;
   endfunction : lead_space

   assign acc_first = PSEL && PENABLE && !s.pready;
   assign acc_done  = PSEL && PENABLE && s.pready;
   assign rx_edge   = IR_RX_IN != s.rx_prev;

   ir_half_unit_tick #(.HALF0(HALF0_CYC), .HALF1(HALF1_CYC)) u_tx_tick (
      .CORE_CLK (CORE_CLK),
      .RESET_N  (RESET_N),
      .clear    (s.tst == irrc_pkg::T_IDLE),
      .fmt      (s.fmt),
      .tick     (tx_tick)
   );

   ir_half_unit_tick #(.HALF0(HALF0_CYC), .HALF1(HALF1_CYC)) u_rx_tick (
      .CORE_CLK (CORE_CLK),
      .RESET_N  (RESET_N),
      .clear    (rx_edge),
      .fmt      (s.fmt),
      .tick     (rx_tick)
   );

   always_comb begin
      n        = s;
      rx_we    = 1'b0;
      rx_waddr = s.rx_wp;
      rx_wdata = `IRRC_RST_BYTE;
      tx_we    = 1'b0;

      // Bus: answer one cycle into the access phase, act on the completing edge.
      if (acc_first) begin
         n.pready  = 1'b1;
         n.prdata  = 32'h00000000;
         n.pslverr = 1'b0;
         if (addr_is(PADDR, `IRRC_IDX_SHARED)) begin
            n.prdata[`IRRC_SH_SUMMARY] = s.sumf;
         end else if (addr_is(PADDR, `IRRC_IDX_CTRL)) begin
            n.prdata[3:0] = {s.tx_done_irq_enable, s.rx_done_irq_enable, s.fmt, s.start};
         end else if (addr_is(PADDR, `IRRC_IDX_STATUS)) begin
            n.prdata[`IRRC_ST_RBFER] = s.rbfer;
            n.prdata[`IRRC_ST_RDI]   = s.rx_frame_done_flag;
            n.prdata[`IRRC_ST_TDI]   = s.tdi;
         end else if (addr_is(PADDR, `IRRC_IDX_RXCNT)) begin
            n.prdata[7:0] = s.rx_occ;
         end else if (addr_is(PADDR, `IRRC_IDX_TXCNT)) begin
            n.prdata[7:0] = s.tx_pend;
         end else if (addr_is(PADDR, `IRRC_IDX_RXFIFO)) begin
            // An empty FIFO answers FF so that over-long reads are recognisable.
            n.prdata[7:0] = (s.rx_occ == 8'h00) ? `IRRC_EMPTY_READ : rx_mem[s.rx_rp];
         end else if (addr_is(PADDR, `IRRC_IDX_TXFIFO)) begin
            n.prdata[7:0] = `IRRC_RST_BYTE;
         end else if (addr_is(PADDR, `IRRC_IDX_TXERR)) begin
            n.prdata[`IRRC_ERR_LEN] = s.lenerr;
         end else begin
            n.pslverr = 1'b1;
         end
      end else if (acc_done) begin
         n.pready  = 1'b0;
         n.pslverr = 1'b0;
      end

      if (acc_done && PWRITE) begin
         if (addr_is(PADDR, `IRRC_IDX_CTRL)) begin
            n.start = PWDATA[`IRRC_CTRL_START];
            n.fmt   = PWDATA[`IRRC_CTRL_FORMAT];
            n.rx_done_irq_enable  = PWDATA[`IRRC_CTRL_RX_DONE_IRQ_ENABLE];
            n.tx_done_irq_enable  = PWDATA[`IRRC_CTRL_TX_DONE_IRQ_ENABLE];
         end else if (addr_is(PADDR, `IRRC_IDX_SHARED)) begin
            if (!PWDATA[`IRRC_SH_SUMMARY]) n.sumf = 1'b0;
         end else if (addr_is(PADDR, `IRRC_IDX_STATUS)) begin
            if (!PWDATA[`IRRC_ST_RDI])   n.rx_frame_done_flag   = 1'b0;
            if (!PWDATA[`IRRC_ST_TDI])   n.tdi   = 1'b0;
            if (!PWDATA[`IRRC_ST_RBFER]) n.rbfer = 1'b0;
         end else if (addr_is(PADDR, `IRRC_IDX_TXERR)) begin
            if (!PWDATA[`IRRC_ERR_LEN]) n.lenerr = 1'b0;
         end else if (addr_is(PADDR, `IRRC_IDX_TXFIFO)) begin
            if (s.tx_fill == 9'(FIFO_DEPTH) || (s.wr_rem != 8'h00 && s.tx_pend == `IRRC_CNT_MAX)) begin
               n.lenerr = 1'b1;
            end else begin
               tx_we   = 1'b1;
               n.tx_wp = s.tx_wp + 8'h01;
               if (s.wr_rem == 8'h00) begin
                  n.wr_rem = PWDATA[7:0];
                  if (PWDATA[7:0] > (`IRRC_CNT_MAX - s.tx_pend)) n.lenerr = 1'b1;
               end else begin
                  n.wr_rem  = s.wr_rem - 8'h01;
                  n.tx_pend = s.tx_pend + 8'h01;
               end
            end
         end
      end
      if (acc_done && !PWRITE && addr_is(PADDR, `IRRC_IDX_RXFIFO) && s.rx_occ != 8'h00) begin
         n.rx_rp  = s.rx_rp + 8'h01;
         n.rx_occ = s.rx_occ - 8'h01;
      end

      // Transmitter: sends only the data bytes, framing is generated here.
      n.tx_fill = s.tx_fill + {8'h00, tx_we};
      if (tx_tick && s.tx_len != 6'd0) n.tx_len = s.tx_len - 6'd1;
      case (s.tst)
         irrc_pkg::T_IDLE: begin
            n.tx_out = 1'b0;
            // A frame starts only once it is wholly in the FIFO, so it never underruns.
            if (s.start && s.tx_fill != 9'h000 && (s.tx_fill - 9'h001) >= {1'b0, tx_mem[s.tx_rp]}) begin
               n.tx_left = tx_mem[s.tx_rp];
               n.tx_rp   = s.tx_rp + 8'h01;
               n.tx_fill = n.tx_fill - 9'h001;
               n.tx_len  = lead_mark(s.fmt) - 6'd1;
               n.tx_out  = 1'b1;
               n.tst     = irrc_pkg::T_LMARK;
            end
         end
         irrc_pkg::T_LMARK: begin
            if (tx_tick && s.tx_len == 6'd0) begin
               n.tx_out = 1'b0;
               n.tx_len = lead_space(s.fmt) - 6'd1;
               n.tst    = irrc_pkg::T_LSPACE;
            end
         end
         irrc_pkg::T_LSPACE, irrc_pkg::T_BSPACE: begin
            if (tx_tick && s.tx_len == 6'd0) begin
               n.tx_out = 1'b1;
               n.tx_len = `IRRC_BIT_MARK - 6'd1;
               n.tst    = irrc_pkg::T_BMARK;
               if (s.tst == irrc_pkg::T_LSPACE) begin
                  n.tx_sh  = tx_mem[s.tx_rp];
                  n.tx_bit = 3'd0;
               end else if (s.tx_bit != 3'd7) begin
                  n.tx_sh  = {1'b0, s.tx_sh[7:1]};
                  n.tx_bit = s.tx_bit + 3'd1;
               end else begin
                  n.tx_rp   = s.tx_rp + 8'h01;
                  n.tx_fill = n.tx_fill - 9'h001;
                  n.tx_left = s.tx_left - 8'h01;
                  n.tx_pend = n.tx_pend - 8'h01;
                  n.tx_sh   = tx_mem[s.tx_rp + 8'h01];
                  n.tx_bit  = 3'd0;
               end
               if ((s.tst == irrc_pkg::T_LSPACE && s.tx_left == 8'h00) ||
                   (s.tst == irrc_pkg::T_BSPACE && s.tx_bit == 3'd7 && s.tx_left == 8'h01)) begin
                  n.tx_len = `IRRC_STOP_MARK - 6'd1;
                  n.tst    = irrc_pkg::T_STOP;
               end
            end
         end
         irrc_pkg::T_BMARK: begin
            if (tx_tick && s.tx_len == 6'd0) begin
               n.tx_out = 1'b0;
               n.tx_len = (s.tx_sh[0] ? `IRRC_ONE_SPACE : `IRRC_ZERO_SPACE) - 6'd1;
               n.tst    = irrc_pkg::T_BSPACE;
            end
         end
         irrc_pkg::T_STOP: begin
            if (tx_tick && s.tx_len == 6'd0) begin
               n.tx_out = 1'b0;
               n.tx_len = `IRRC_TRAIL_SPACE - 6'd1;
               n.tst    = irrc_pkg::T_TRAIL;
            end
         end
         irrc_pkg::T_TRAIL: begin
            if (tx_tick && s.tx_len == 6'd0) begin
               n.tdi  = 1'b1;
               n.sumf = 1'b1;
               n.tst  = irrc_pkg::T_IDLE;
            end
         end
         default: begin
            n.tst    = irrc_pkg::T_IDLE;
            n.tx_out = 1'b0;
         end
      endcase

      // Receiver: widths measured in half units between input edges.
      n.rx_prev = IR_RX_IN;
      if (rx_edge) begin
         n.rx_len = 6'd0;
      end else if (rx_tick && s.rx_len != `IRRC_LEN_MAX) begin
         n.rx_len = s.rx_len + 6'd1;
      end
      if (!s.start) begin
         n.rx_in_fr = 1'b0;
      end else if (rx_edge && !IR_RX_IN && s.rx_len >= `IRRC_RX_LEAD_MIN) begin
         n.rx_in_fr = 1'b1;
         n.rx_skip  = 1'b1;
         n.rx_drop  = 1'b0;
         n.rx_fb    = 8'h00;
         n.rx_bit   = 3'd0;
      end else if (s.rx_in_fr && rx_edge && IR_RX_IN) begin
         n.rx_skip = 1'b0;
         if (!s.rx_skip) begin
            n.rx_sh  = {(s.rx_len >= `IRRC_RX_ONE_MIN), s.rx_sh[7:1]};
            n.rx_bit = s.rx_bit + 3'd1;
            if (s.rx_bit == 3'd7) begin
               // Room is needed for this byte and for the frame's count slot.
               if (!s.rx_drop && s.rx_fb != `IRRC_CNT_MAX &&
                   ({2'b00, s.rx_occ} + {2'b00, s.rx_fb} + 10'd2) <= {2'b00, `IRRC_CNT_MAX}) begin
                  rx_we    = 1'b1;
                  rx_waddr = s.rx_wp + 8'h01 + s.rx_fb;
                  rx_wdata = n.rx_sh;
                  n.rx_fb  = s.rx_fb + 8'h01;
               end else begin
                  n.rx_drop = 1'b1;
                  n.rbfer   = 1'b1;
               end
            end
         end
      end else if (s.rx_in_fr && !IR_RX_IN && !s.rx_skip && s.rx_len >= `IRRC_RX_END) begin
         n.rx_in_fr = 1'b0;
         if (({1'b0, s.rx_occ} + {1'b0, s.rx_fb}) < {1'b0, `IRRC_CNT_MAX}) begin
            rx_we    = 1'b1;
            rx_waddr = s.rx_wp;
            rx_wdata = s.rx_fb;
            n.rx_wp  = s.rx_wp + 8'h01 + s.rx_fb;
            n.rx_occ = n.rx_occ + 8'h01 + s.rx_fb;
            n.rx_frame_done_flag    = 1'b1;
            n.sumf   = 1'b1;
         end else begin
            n.rbfer = 1'b1;
         end
      end

      n.irq = (n.rx_frame_done_flag && n.rx_done_irq_enable) || (n.tdi && n.tx_done_irq_enable);
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         s     <= '0;
         s.tst <= irrc_pkg::T_IDLE;
      end else begin
         s <= n;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (rx_we) rx_mem[rx_waddr] <= rx_wdata;
      if (tx_we) tx_mem[s.tx_wp] <= PWDATA[7:0];
   end

   assign PREADY    = s.pready;
   assign PRDATA    = s.prdata;
   assign PSLVERR   = s.pslverr;
   assign IR_TX_OUT = s.tx_out;
   assign IR_IRQ    = s.irq;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);

   chk_rx_count_cap: assert property (
      s.rx_occ <= `IRRC_CNT_MAX && !(s.rx_occ == 8'h00 && $past(s.rx_occ) == 8'hFF))
      else $error("receive count wrapped");
   chk_empty_ff: assert property (
      acc_first && !PWRITE && addr_is(PADDR, `IRRC_IDX_RXFIFO) && s.rx_occ == 8'h00
      |=> PRDATA[7:0] == 8'hFF)
      else $error("empty receive read did not return FF");
   chk_pop_once: assert property (
      acc_done && !PWRITE && addr_is(PADDR, `IRRC_IDX_RXFIFO) && s.rx_occ != 8'h00
      && !(s.rx_in_fr && !IR_RX_IN && s.rx_len >= `IRRC_RX_END)
      |=> s.rx_occ == $past(s.rx_occ) - 8'h01)
      else $error("receive read did not pop one byte");
   chk_count_excl: assert property (
      acc_done && PWRITE && addr_is(PADDR, `IRRC_IDX_TXFIFO) && s.wr_rem == 8'h00
      && s.tst == irrc_pkg::T_IDLE |=> s.tx_pend == $past(s.tx_pend))
      else $error("count byte entered the pending count");
   chk_frame_done: assert property (
      s.tst == irrc_pkg::T_TRAIL && tx_tick && s.tx_len == 6'd0
      |=> s.tdi && s.sumf && s.tst == irrc_pkg::T_IDLE)
      else $error("frame end did not set transmit flags");
   chk_sum_hold: assert property (
      s.sumf && !(acc_done && PWRITE && addr_is(PADDR, `IRRC_IDX_SHARED)
      && !PWDATA[`IRRC_SH_SUMMARY]) |=> s.sumf)
      else $error("summary flag cleared without a zero write");
   chk_irq_level: assert property (
      ##1 IR_IRQ == ((s.rx_frame_done_flag && s.rx_done_irq_enable) || (s.tdi && s.tx_done_irq_enable)))
      else $error("interrupt does not follow enabled flags");
   chk_lead_mark: assert property (
      $rose(s.tst == irrc_pkg::T_LMARK) |-> IR_TX_OUT ##1 (IR_TX_OUT [*8]))
      else $error("leader mark too short");
   chk_idle_start: assert property (
      !s.start && s.tst == irrc_pkg::T_IDLE |=> s.tst == irrc_pkg::T_IDLE && !s.rx_in_fr)
      else $error("activity while start is clear");
   chk_overflow: assert property (
      s.start && rx_edge && IR_RX_IN && s.rx_in_fr && !s.rx_skip && s.rx_bit == 3'd7
      && s.rx_occ == 8'hFF |=> s.rbfer)
      else $error("full receive buffer did not flag error");
   chk_len_err: assert property (
      acc_done && PWRITE && addr_is(PADDR, `IRRC_IDX_TXFIFO) && s.tx_fill == 9'h100
      |=> s.lenerr)
      else $error("write into full transmit FIFO not flagged");

   cov_tx_frame: cover property (s.tst == irrc_pkg::T_TRAIL ##1 s.tst == irrc_pkg::T_IDLE);
   cov_rx_commit: cover property ($rose(s.rx_frame_done_flag));
   cov_overflow: cover property ($rose(s.rbfer));
   cov_len_err: cover property ($rose(s.lenerr));
endmodule : infrared_remote_transceiver

/* File: test/ir_far_end.sv */
`timescale 1ns/10ps
module ir_far_end #(
   parameter int HALF = 4
) (
   input  wire logic CORE_CLK, // System clock.
   input  wire logic emit_in,  // Emitter drive from the block, high during mark.
   output logic      recv_out  // Demodulated line into the block, high during mark.
);
   logic [7:0] got[$];
   int         frames;
   int         lead_len;
   int         run;
   int         nb;
   logic       prev;
   logic       skip;
   logic [7:0] sh;

   initial begin
      recv_out = 1'b0;
      prev     = 1'b0;
      skip     = 1'b0;
      sh       = 8'h00;
      frames   = 0;
      lead_len = 0;
      run      = 0;
      nb       = 0;
   end

   // A long space or the next leader closes a frame, so back-to-back frames are both seen.
   always @(posedge CORE_CLK) begin
      if (emit_in === prev) begin
         run = run + 1;
         if (!prev && run == 20 * HALF && nb > 0) begin
            frames = frames + 1;
            nb     = 0;
         end
      end else begin
         if (!emit_in && run >= 12 * HALF) begin
            skip     = 1'b1;
            lead_len = run;
         end else if (emit_in && skip) begin
            skip = 1'b0;
         end else if (emit_in && run >= 12 * HALF) begin
            if (nb > 0) frames = frames + 1;
            nb = 0;
         end else if (emit_in) begin
            sh = {(run >= 4 * HALF), sh[7:1]};
            nb = nb + 1;
            if (nb % 8 == 0) got.push_back(sh);
         end
         run = 1;
      end
      prev = emit_in;
   end

   task automatic hold(input logic v, input int n);
      recv_out <= v;
      repeat (n) @(posedge CORE_CLK);
   endtask : hold

   // The closing space outlasts the end-of-frame gap with a margin for tick phase.
   task automatic send(input logic [7:0] b[$]);
      hold(1'b1, 32 * HALF);
      hold(1'b0, 16 * HALF);
      foreach (b[i]) begin
         for (int k = 0; k < 8; k++) begin
            hold(1'b1, 2 * HALF);
            hold(1'b0, b[i][k] ? 6 * HALF : 2 * HALF);
         end
      end
      hold(1'b1, 2 * HALF);
      hold(1'b0, 28 * HALF);
   endtask : send
endmodule : ir_far_end

/* File: test/tb.sv */
`timescale 1ns/10ps
`include "irrc_defines.svh"
module tb;
   localparam int HALF = 4;
   logic        CORE_CLK;
   logic        RESET_N;
   logic        PSEL;
   logic        PENABLE;
   logic        PWRITE;
   logic [11:0] PADDR;
   logic [31:0] PWDATA;
   logic [31:0] PRDATA;
   logic        PREADY;
   logic        PSLVERR;
   logic        IR_TX_OUT;
   logic        IR_RX_IN;
   logic        IR_IRQ;
   logic [31:0] rdata;
   logic        rerr;
   logic [7:0]  q[$];
   logic [9:0]  rst_idx[6];
   int          errors;
   int          compares;
   int          wait_n;

   initial CORE_CLK = 1'b0;
   always #5 CORE_CLK = ~CORE_CLK;

   infrared_remote_transceiver #(.HALF0_CYC(HALF), .HALF1_CYC(HALF)) dut (
      .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
      .PRDATA(PRDATA), .PSLVERR(PSLVERR), .IR_TX_OUT(IR_TX_OUT),
      .IR_RX_IN(IR_RX_IN), .IR_IRQ(IR_IRQ));
   ir_far_end #(.HALF(HALF)) far (.CORE_CLK(CORE_CLK), .emit_in(IR_TX_OUT), .recv_out(IR_RX_IN));

   task automatic stop_test();
      if (errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // Entered just after a rising edge; an idle cycle follows so the next setup is clean.
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      int n;
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= {idx, 2'b00};
      PWDATA <= {24'h0, wd};
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      rdata = PRDATA;
      rerr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (PREADY !== 1'b1) begin
         check("pready timeout", 0, 1);
         stop_test();
      end else begin
         @(posedge CORE_CLK);
      end
   endtask : apb

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      check($sformatf("reg %h", idx), rdata, {24'h0, e});
   endtask : rdc

   initial begin
      errors = 0;
      compares = 0;
      RESET_N = 1'b0;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      rst_idx = '{`IRRC_IDX_SHARED, `IRRC_IDX_CTRL, `IRRC_IDX_STATUS, `IRRC_IDX_RXCNT,
                  `IRRC_IDX_TXCNT, `IRRC_IDX_TXFIFO};
      repeat (4) @(posedge CORE_CLK);
      RESET_N <= 1'b1;
      @(posedge CORE_CLK);
      check("tx idle", IR_TX_OUT, 0);
      for (int i = 0; i < 6; i++) rdc(rst_idx[i], 8'h00);
      rdc(`IRRC_IDX_RXFIFO, 8'hFF);
      apb(1'b0, 10'h3FF, 8'h00);
      check("unmapped", rerr, 1);
      wr(`IRRC_IDX_RXCNT, 8'h55);
      rdc(`IRRC_IDX_RXCNT, 8'h00);
      for (int f = 0; f < 2; f++) begin
         wr(`IRRC_IDX_CTRL, 8'h00);
         wr(`IRRC_IDX_TXFIFO, 8'h02);
         wr(`IRRC_IDX_TXFIFO, 8'hA5);
         wr(`IRRC_IDX_TXFIFO, 8'h3C);
         rdc(`IRRC_IDX_TXCNT, 8'h02);
         wr(`IRRC_IDX_CTRL, {6'h0, f[0], 1'b0});
         wr(`IRRC_IDX_CTRL, {4'h0, 2'b10, f[0], 1'b1});
         wait_n = 0;
         while (wait_n < 5000 && !(IR_IRQ === 1'b1 && far.frames == f + 1)) begin
            @(posedge CORE_CLK);
            wait_n++;
         end
         if (!(IR_IRQ === 1'b1 && far.frames == f + 1)) begin
            check("tx frame timeout", 0, 1);
            stop_test();
         end
         check("frames", far.frames, f + 1);
         check("byte0", far.got[0], 8'hA5);
         check("byte1", far.got[1], 8'h3C);
         check("leader", far.lead_len >= (32 - 16 * f) * HALF - HALF - 1
               && far.lead_len <= (32 - 16 * f) * HALF + HALF + 1, 1);
         far.got.delete();
         rdc(`IRRC_IDX_STATUS, 8'h08);
         rdc(`IRRC_IDX_SHARED, 8'h10);
         rdc(`IRRC_IDX_TXCNT, 8'h00);
         wr(`IRRC_IDX_STATUS, 8'h08);
         rdc(`IRRC_IDX_STATUS, 8'h08);
         wr(`IRRC_IDX_STATUS, 8'h00);
         rdc(`IRRC_IDX_STATUS, 8'h00);
         check("irq low", IR_IRQ, 0);
         wr(`IRRC_IDX_SHARED, 8'h10);
         rdc(`IRRC_IDX_SHARED, 8'h10);
         wr(`IRRC_IDX_SHARED, 8'h00);
         rdc(`IRRC_IDX_SHARED, 8'h00);
      end
      wr(`IRRC_IDX_CTRL, 8'h05);
      q = '{8'h11, 8'h22, 8'h83};
      far.send(q);
      check("irq rx", IR_IRQ, 1);
      rdc(`IRRC_IDX_RXCNT, 8'h04);
      rdc(`IRRC_IDX_STATUS, 8'h04);
      rdc(`IRRC_IDX_SHARED, 8'h10);
      q = '{8'h5A};
      far.send(q);
      rdc(`IRRC_IDX_RXCNT, 8'h06);
      q = '{8'h03, 8'h11, 8'h22, 8'h83, 8'h01, 8'h5A};
      foreach (q[i]) rdc(`IRRC_IDX_RXFIFO, q[i]);
      rdc(`IRRC_IDX_RXCNT, 8'h00);
      rdc(`IRRC_IDX_RXFIFO, 8'hFF);
      wr(`IRRC_IDX_CTRL, 8'h00);
      wr(`IRRC_IDX_TXFIFO, 8'h01);
      wr(`IRRC_IDX_TXFIFO, 8'h77);
      rdc(`IRRC_IDX_TXCNT, 8'h01);
      wr(`IRRC_IDX_TXFIFO, 8'hFF);
      rdc(`IRRC_IDX_TXERR, 8'h01);
      wr(`IRRC_IDX_TXERR, 8'h00);
      rdc(`IRRC_IDX_TXERR, 8'h00);
      RESET_N <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RESET_N <= 1'b1;
      @(posedge CORE_CLK);
      rdc(`IRRC_IDX_TXCNT, 8'h00);
      wr(`IRRC_IDX_TXFIFO, 8'hFF);
      for (int i = 0; i < 255; i++) wr(`IRRC_IDX_TXFIFO, 8'(i));
      rdc(`IRRC_IDX_TXCNT, 8'hFF);
      rdc(`IRRC_IDX_TXERR, 8'h00);
      wr(`IRRC_IDX_TXFIFO, 8'h00);
      rdc(`IRRC_IDX_TXERR, 8'h01);
      rdc(`IRRC_IDX_TXCNT, 8'hFF);
      stop_test();
   end
endmodule : tb
